/* fsps_pkg.sv */
// Package for the flash self-program sequencer: register map, bit positions, timing and carrier types.
// Assumes a 100 MHz system clock and a classic Wishbone slave with 32-bit data.
`default_nettype none
package fsps_pkg;
   localparam int          CLK_MHZ       = 100;
   localparam int          OP_TIME_US    = 2000;
   localparam int          OP_CYCLES     = OP_TIME_US * CLK_MHZ;
   localparam int          ROW_BITS      = 10;
   localparam int          LATCH_BITS    = 5;
   localparam int          LATCHES       = 32;
   localparam int          WORD_BITS     = 14;
   localparam logic [13:0] BLANK_WORD    = 14'h3fff;
   localparam logic [7:0]  KEY_FIRST     = 8'h55;
   localparam logic [7:0]  KEY_SECOND    = 8'haa;
   localparam logic [1:0]  NOP_SLOTS     = 2'h2;
   // Word offsets (byte addresses).
   localparam logic [7:0]  ADR_CONTROL   = 8'h00;
   localparam logic [7:0]  ADR_KEY       = 8'h04;
   localparam logic [7:0]  ADR_ADDR_LOW  = 8'h08;
   localparam logic [7:0]  ADR_ADDR_HIGH = 8'h0c;
   localparam logic [7:0]  ADR_DATA_LOW  = 8'h10;
   localparam logic [7:0]  ADR_DATA_HIGH = 8'h14;
   // Control register bit positions.
   localparam int          B_RD          = 0;
   localparam int          B_WR          = 1;
   localparam int          B_WRITE_EN    = 2;
   localparam int          B_ABORT       = 3;
   localparam int          B_ERASE       = 4;
   localparam int          B_LATCH_ONLY  = 5;
   localparam int          B_CFG_SEL     = 6;
   localparam int          B_BUSY        = 7;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_NOP   = 5'b00010,
      ST_STALL = 5'b00100,
      ST_CLEAR = 5'b01000,
      ST_READ  = 5'b10000
   } fsps_state_e;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [14:0] addr;
      logic [13:0] wdata;
   } fsps_flash_req_s;
endpackage
`default_nettype wire

/* fsps_latch_mem.sv */
// Row latch buffer: one 14-bit word per latch, registered read port, bulk blank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module fsps_latch_mem
   import fsps_pkg::*;
#(
   parameter int DEPTH = LATCHES,
   parameter int AW    = LATCH_BITS
)(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 we_i,
   input  wire logic [AW-1:0]        waddr_i,
   input  wire logic [WORD_BITS-1:0] wdata_i,
   input  wire logic                 blank_i,
   input  wire logic [AW-1:0]        raddr_i,
   output logic      [WORD_BITS-1:0] rdata_o
);
   logic [WORD_BITS-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         if (rst_i || blank_i)
            mem_q[i] <= BLANK_WORD;
         else if (we_i && waddr_i == AW'(i))
            mem_q[i] <= wdata_i;
      end
      rdata_o <= rst_i ? BLANK_WORD : mem_q[raddr_i];
   end
endmodule // fsps_latch_mem
`default_nettype wire

/* fsps_seq.sv */
// Flash self-program sequencer: unlock tracking, latch loads, row erase/program, read, CPU stall.
// Assumes a classic Wishbone master on the CPU side and a flash array reached through flash_o/flash_done_i.
`timescale 1ns/100ps
`default_nettype none
module fsps_seq
   import fsps_pkg::*;
#(
   parameter int OP_CYC = OP_CYCLES
)(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   input  wire logic                 we_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   output logic                      ack_o,
   output logic                      err_o,
   output logic                      force_nop_o,
   output logic                      stall_o,
   output fsps_flash_req_s           flash_o,
   output logic                      flash_erase_o,
   output logic                      flash_cfg_o,
   output logic      [LATCH_BITS-1:0] flash_latch_idx_o,
   input  wire logic [WORD_BITS-1:0] flash_latch_word_unused_i,
   input  wire logic                 flash_done_i,
   input  wire logic [WORD_BITS-1:0] flash_rdata_i
);
   logic [7:0]           ctrl_q, ctrl_d;
   logic [7:0]           adrl_q, adrh_q, datl_q, dath_q;
   logic [1:0]           key_q, key_d;
   logic [1:0]           nop_q;
   logic [31:0]          wait_q;
   logic                 op_long_q;
   logic                 ack_q;
   logic                 rd_pend_q;
   logic                 abort_seen_q;
   fsps_state_e          state_q;
   logic [WORD_BITS-1:0] latch_rdata;
   logic                 run_q;
   logic [LATCH_BITS-1:0] idx_q;
   logic [LATCH_BITS-1:0] idx_rd_q;

   wire req       = cyc_i && stb_i && !ack_q;
   wire wr_req    = req && we_i && sel_i[0];
   wire hit_ctrl  = adr_i == ADR_CONTROL;
   wire hit_key   = adr_i == ADR_KEY;
   wire hit_adrl  = adr_i == ADR_ADDR_LOW;
   wire hit_adrh  = adr_i == ADR_ADDR_HIGH;
   wire hit_datl  = adr_i == ADR_DATA_LOW;
   wire hit_dath  = adr_i == ADR_DATA_HIGH;
   wire mapped    = hit_ctrl || hit_key || hit_adrl || hit_adrh || hit_datl || hit_dath;
   wire idle      = state_q == ST_IDLE;
   wire [14:0] addr    = {adrh_q[6:0], adrl_q};
   wire [13:0] wword   = {dath_q[5:0], datl_q};
   wire key_wr    = wr_req && hit_key;
   // Any bus write to byte 0 other than the second key byte breaks a half-done unlock, except a control write with WR set while busy.
   wire other_wr  = wr_req && !hit_key && !(hit_ctrl && dat_i[B_WR]);
   wire go_wr     = wr_req && hit_ctrl && dat_i[B_WR] && idle;
   wire armed     = go_wr && key_q == 2'h2;
   wire enabled   = armed && dat_i[B_WRITE_EN];
   wire do_load   = enabled && dat_i[B_LATCH_ONLY] && !dat_i[B_ERASE];
   wire do_erase  = enabled && dat_i[B_ERASE] && !dat_i[B_CFG_SEL];
   wire do_prog   = enabled && !dat_i[B_LATCH_ONLY] && !dat_i[B_ERASE];
   wire go_rd     = wr_req && hit_ctrl && dat_i[B_RD] && idle;
   // A program stall lasts at least long enough to stream every latch, however short the timer is set.
   wire row_done  = ctrl_q[B_ERASE] || idx_q == LATCH_BITS'(LATCHES - 1);

   // Key tracking.
   always_comb
   begin
      key_d = key_q;
      if (key_wr && dat_i[7:0] == KEY_FIRST && key_q == 2'h0)
         key_d = 2'h1;
      else if (key_wr && dat_i[7:0] == KEY_SECOND && key_q == 2'h1)
         key_d = 2'h2;
      else if (key_wr || other_wr || go_wr)
         key_d = 2'h0;
   end

   // Control register: WR and RD only settable by software.
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_req && hit_ctrl)
      begin
         ctrl_d[B_WRITE_EN]   = dat_i[B_WRITE_EN];
         ctrl_d[B_ERASE]      = dat_i[B_ERASE];
         ctrl_d[B_LATCH_ONLY] = dat_i[B_LATCH_ONLY];
         ctrl_d[B_CFG_SEL]    = dat_i[B_CFG_SEL];
         ctrl_d[B_ABORT]      = ctrl_q[B_ABORT] & dat_i[B_ABORT];
         // Without a full unlock and write enable the start bit does not stick.
         if (enabled)
            ctrl_d[B_WR] = 1'b1;
         if (go_rd)
            ctrl_d[B_RD] = 1'b1;
      end
      if (state_q == ST_CLEAR || (state_q == ST_NOP && nop_q == 2'h1 && !op_long_q))
         ctrl_d[B_WR] = 1'b0;
      if (state_q == ST_READ)
         ctrl_d[B_RD] = 1'b0;
      if (abort_seen_q)
         ctrl_d[B_ABORT] = 1'b1;
      ctrl_d[B_BUSY] = !idle;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q  <= 8'h00;
         key_q   <= 2'h0;
         ack_q   <= 1'b0;
      end
      else
      begin
         ctrl_q  <= ctrl_d;
         key_q   <= key_d;
         ack_q   <= cyc_i && stb_i && !ack_q;
      end
   end

   // A reset landing while the sequencer is in ST_STALL is remembered through reset so the flag survives it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         abort_seen_q <= abort_seen_q || (state_q == ST_STALL);
      else
         abort_seen_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         adrl_q <= 8'h00;
         adrh_q <= 8'h00;
      end
      else
      begin
         if (wr_req && hit_adrl)
            adrl_q <= dat_i[7:0];
         if (wr_req && hit_adrh)
            adrh_q <= {1'b0, dat_i[6:0]};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         datl_q <= 8'h00;
         dath_q <= 8'h00;
      end
      else if (state_q == ST_READ)
      begin
         datl_q <= flash_rdata_i[7:0];
         dath_q <= {2'h0, flash_rdata_i[13:8]};
      end
      else
      begin
         if (wr_req && hit_datl)
            datl_q <= dat_i[7:0];
         if (wr_req && hit_dath)
            dath_q <= {2'h0, dat_i[5:0]};
      end
   end

   // Sequencer: forced slots, then an optional stall for erase or program.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q   <= ST_IDLE;
         nop_q     <= 2'h0;
         wait_q    <= 32'h0;
         op_long_q <= 1'b0;
         rd_pend_q <= 1'b0;
         run_q     <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (enabled)
               begin
                  state_q   <= ST_NOP;
                  nop_q     <= NOP_SLOTS;
                  op_long_q <= do_erase || do_prog;
                  run_q     <= do_erase || do_prog;
               end
               else if (go_rd)
               begin
                  state_q   <= ST_NOP;
                  nop_q     <= NOP_SLOTS;
                  op_long_q <= 1'b0;
                  rd_pend_q <= 1'b1;
               end
            ST_NOP:
            begin
               nop_q <= nop_q - 2'h1;
               if (nop_q == 2'h1)
               begin
                  if (rd_pend_q)
                     state_q <= ST_READ;
                  else if (op_long_q)
                  begin
                     state_q <= ST_STALL;
                     wait_q  <= 32'(OP_CYC);
                  end
                  else
                     state_q <= ST_IDLE;
               end
            end
            ST_STALL:
            begin
               run_q <= 1'b0;
               if (wait_q != 32'h0)
                  wait_q <= wait_q - 32'h1;
               if (wait_q <= 32'h1 && flash_done_i && row_done)
                  state_q <= ST_CLEAR;
            end
            ST_CLEAR:
               state_q <= ST_IDLE;
            ST_READ:
            begin
               rd_pend_q <= 1'b0;
               state_q   <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Programming walks the latch buffer once; it never issues an erase.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_q != ST_STALL)
         idx_q <= '0;
      else if (!ctrl_q[B_ERASE] && idx_q != LATCH_BITS'(LATCHES - 1))
         idx_q <= idx_q + 1'b1;
   end

   // The latch read port is registered, so the word read from a latch lags the index by one cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         idx_rd_q <= '0;
      else
         idx_rd_q <= idx_q;
   end

   fsps_latch_mem #(
      .DEPTH (LATCHES),
      .AW    (LATCH_BITS)
   ) u_latch (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (do_load || do_prog),
      .waddr_i (addr[LATCH_BITS-1:0]),
      .wdata_i (wword),
      .blank_i (state_q == ST_CLEAR),
      .raddr_i (idx_q),
      .rdata_o (latch_rdata)
   );

   // Clocks keep running during the stall; only instruction issue is held.
   assign stall_o           = state_q == ST_STALL || state_q == ST_CLEAR;
   assign force_nop_o       = state_q == ST_NOP;
   assign flash_erase_o     = ctrl_q[B_ERASE];
   assign flash_cfg_o       = ctrl_q[B_CFG_SEL];
   assign flash_latch_idx_o = idx_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flash_o <= '0;
      else
      begin
         flash_o.req   <= run_q || state_q == ST_READ || (state_q == ST_NOP && rd_pend_q && nop_q == 2'h1);
         flash_o.we    <= op_long_q;
         flash_o.addr  <= rd_pend_q ? addr
                                    : {addr[14:LATCH_BITS], ctrl_q[B_ERASE] ? LATCH_BITS'(0) : idx_rd_q};
         flash_o.wdata <= latch_rdata;
      end
   end

   wire [7:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_adrl ? adrl_q :
                       hit_adrh ? adrh_q :
                       hit_datl ? datl_q :
                       hit_dath ? dath_q : 8'h00;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0;
      else if (req)
         dat_o <= {24'h0, rd_mux};
   end

   assign ack_o = ack_q && mapped;
   assign err_o = ack_q && !mapped;
endmodule // fsps_seq
`default_nettype wire

/* fsps_seq_sva.sv */
// Checker for the sequencer: bus answers, forced no-operation slots, stall length and key readback.
// Assumes it is bound to every sequencer instance and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module fsps_seq_sva
   import fsps_pkg::*;
#(
   parameter int OP_CYC = OP_CYCLES
)(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        we_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        force_nop_o,
   input wire logic        stall_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] run_q;
   wire         take   = cyc_i && stb_i && !ack_o && !err_o;
   wire         mapped = (adr_i <= ADR_DATA_HIGH) && (adr_i[1:0] == 2'h0);
   // Counts the cycles of the present stall so its length can be judged when it ends.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !stall_o) run_q <= 32'h0;
      else run_q <= run_q + 32'h1;
   end
   a_ack_mapped: assert property (take && mapped |=> ack_o && !err_o)
      else $error("mapped access not acknowledged next cycle");
   a_err_unmapped: assert property (take && !mapped |=> err_o && !ack_o)
      else $error("unmapped access not refused next cycle");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   a_nop_pair: assert property ($rose(force_nop_o) |-> force_nop_o ##1 force_nop_o ##1 !force_nop_o)
      else $error("forced slots not exactly two");
   a_nop_cause: assert property ($rose(force_nop_o) |-> ack_o && we_i && adr_i == ADR_CONTROL)
      else $error("forced slots without control write");
   a_stall_entry: assert property ($rose(stall_o) |-> $past(force_nop_o, 1) && $past(force_nop_o, 2))
      else $error("stall did not follow the two slots");
   a_stall_length: assert property ($fell(stall_o) && !$past(rst_i) |-> run_q >= OP_CYC + 1)
      else $error("stall ended early");
   a_key_zero: assert property (ack_o && !we_i && adr_i == ADR_KEY |-> dat_o == 32'h0)
      else $error("key register read not zero");
   a_busy_shown: assert property (ack_o && !we_i && adr_i == ADR_CONTROL && stall_o && $past(stall_o)
      |-> dat_o[B_BUSY])
      else $error("busy not shown during stall");
endmodule // fsps_seq_sva
bind fsps_seq fsps_seq_sva #(.OP_CYC(OP_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_o(dat_o),
   .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .force_nop_o(force_nop_o),
   .stall_o(stall_o));
`default_nettype wire

/* fsps_flash_model.sv */
// Behavioural flash array behind the sequencer: busy for a chosen delay, read data from the address.
// Assumes one clock shared with the sequencer and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module fsps_flash_model
   import fsps_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire fsps_flash_req_s      flash_i,
   input  wire logic [7:0]           dly_i,
   output logic                      done_o,
   output logic      [WORD_BITS-1:0] rdata_o
);
   logic [7:0]           cnt_q;
   wire  [WORD_BITS-1:0] word = flash_i.addr[WORD_BITS-1:0] ^ 14'h2a5c;
   assign done_o = (cnt_q == 8'h00) && !flash_i.req;
   // Read data stands only while a read request stands; otherwise the inverse shows, so a late capture fails.
   assign rdata_o = (flash_i.req && !flash_i.we) ? word : ~word;
   always_ff @(posedge clk_i)
   begin
      if (rst_i) cnt_q <= 8'h00;
      else if (flash_i.req) cnt_q <= dly_i;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
endmodule // fsps_flash_model
`default_nettype wire

/* flash_self_program_sequencer_tb.sv */
// Self-checking bench: unlock cases, latch load, erase, program, read, abort by reset, unmapped access.
// Assumes the sequencer, its checker and the flash model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module flash_self_program_sequencer_tb
   import fsps_pkg::*;
();
   localparam int         OPC = 40;
   localparam logic [7:0] WR = 8'h02, EN = 8'h04, ER = 8'h10, LO = 8'h20, CF = 8'h40;
   logic                  clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, e;
   logic [7:0]            adr = 8'h00, dly = 8'h00, lo_b;
   logic [31:0]           wdat = 32'h0, q, rdat;
   logic                  ack, err, nop, stall, done, fer, fcfg;
   logic [4:0]            fidx;
   logic [13:0]           frd, d_r;
   logic [14:0]           a_r;
   fsps_flash_req_s       flash_w;
   int                    n_errors = 0, comparisons = 0, seed = 69, nop_tot = 0, st_tot = 0, req_tot = 0, top_tot = 0;
   logic [7:0]            c_k [9] = '{8'haa, 8'h12, 8'haa, 8'haa, 8'haa, 8'haa, 8'haa, 8'haa, 8'haa};
   // Latches are loaded with latch-only set, the row write clears it.
   logic [7:0]            c_ctl [9] = '{WR|EN|LO, WR|EN|LO, WR|EN|LO, WR|LO, WR|EN|ER, WR|EN, 8'h01, WR|EN|ER|CF, WR|EN};
   logic [8:0]            c_mid = 9'h004, c_act = 9'h1f1;
   always #5 clk_i = ~clk_i;
   fsps_seq #(.OP_CYC(OPC)) uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we),
      .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .err_o(err), .force_nop_o(nop), .stall_o(stall),
      .flash_o(flash_w), .flash_erase_o(fer), .flash_cfg_o(fcfg), .flash_latch_idx_o(fidx),
      .flash_latch_word_unused_i(14'h0),
      .flash_done_i(done), .flash_rdata_i(frd));
   fsps_flash_model u_flash (.clk_i(clk_i), .rst_i(rst_i), .flash_i(flash_w), .dly_i(dly), .done_o(done),
      .rdata_o(frd));
   always @(posedge clk_i)
   begin
      if (nop === 1'b1) nop_tot++;
      if (stall === 1'b1) st_tot++;
      if (flash_w.req === 1'b1) req_tot++;
      if (fidx === 5'h1f) top_tot++;
   end
   function automatic logic [13:0] exp_rd(input logic [14:0] a);
      return a[13:0] ^ 14'h2a5c;
   endfunction
   task end_of_test();
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Classic single cycle; the request stands until the edge that samples the answer.
   task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int t;
      begin
         t = 0;
         @(posedge clk_i);
         adr <= a;
         we <= w;
         wdat <= {24'h0, d};
         cyc <= 1'b1;
         stb <= 1'b1;
         do
         begin
            @(posedge clk_i);
            t++;
         end
         while (ack !== 1'b1 && err !== 1'b1 && t < 50);
         q = rdat;
         e = err;
         if (t >= 50) n_errors++;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task op(input logic [7:0] k, input logic mid, input logic [7:0] ctl, input logic act, input logic slow);
      int n0, s0, r0, x0, ds, t;
      logic lng;
      begin
         n0 = nop_tot;
         s0 = st_tot;
         r0 = req_tot;
         x0 = top_tot;
         t = 0;
         // Nothing else reaches the bus between the key bytes unless mid adds an address write, as with interrupts held off.
         wb(ADR_KEY, 1'b1, KEY_FIRST);
         if (mid) wb(ADR_ADDR_LOW, 1'b1, 8'h00);
         wb(ADR_KEY, 1'b1, k);
         wb(ADR_CONTROL, 1'b1, ctl);
         // The polls during the forced slots only read, standing in for the two no-operation instructions.
         do
         begin
            wb(ADR_CONTROL, 1'b0, 8'h00);
            t++;
         end
         while (q[1:0] !== 2'b00 && t < 100);
         `CHK(t < 100, 1'b1)
         ds = st_tot - s0;
         lng = act && !ctl[B_LATCH_ONLY] && !ctl[B_RD] && !(ctl[B_ERASE] && ctl[B_CFG_SEL]);
         `CHK(nop_tot - n0, act ? 2 : 0)
         `CHK(slow ? ds > OPC : ds == (lng ? OPC + 1 : 0), 1'b1)
         `CHK(req_tot > r0, lng || (act && ctl[B_RD]))
         `CHK(top_tot > x0, lng && !ctl[B_ERASE])
         `CHK({fcfg, fer}, {ctl[B_CFG_SEL], ctl[B_ERASE]})
      end
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(ADR_CONTROL, 1'b0, 8'h00);
      `CHK(q[7:0], 8'h00)
      wb(ADR_KEY, 1'b0, 8'h00);
      `CHK(q, 32'h0)
      wb(8'h40, 1'b1, 8'h11);
      `CHK(e, 1'b1)
      for (int i = 0; i < 9; i++)
      begin
         a_r = 15'($random(seed));
         d_r = 14'($random(seed));
         dly <= (i == 8) ? 8'h50 : 8'($random(seed)) & 8'h0f;
         wb(ADR_ADDR_LOW, 1'b1, a_r[7:0]);
         wb(ADR_ADDR_HIGH, 1'b1, {1'b0, a_r[14:8]});
         wb(ADR_DATA_LOW, 1'b1, d_r[7:0]);
         wb(ADR_DATA_HIGH, 1'b1, {2'b00, d_r[13:8]});
         op(c_k[i], c_mid[i], c_ctl[i], c_act[i], i == 8);
         if (c_ctl[i] == 8'h01)
         begin
            wb(ADR_DATA_LOW, 1'b0, 8'h00);
            lo_b = q[7:0];
            wb(ADR_DATA_HIGH, 1'b0, 8'h00);
            `CHK({q[5:0], lo_b}, exp_rd(a_r))
         end
      end
      wb(ADR_KEY, 1'b1, KEY_FIRST);
      wb(ADR_KEY, 1'b1, KEY_SECOND);
      wb(ADR_CONTROL, 1'b1, WR|EN|ER);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(ADR_CONTROL, 1'b0, 8'h00);
      `CHK(q[B_ABORT], 1'b1)
      wb(ADR_CONTROL, 1'b1, 8'h00);
      wb(ADR_CONTROL, 1'b0, 8'h00);
      `CHK(q[7:0], 8'h00)
      end_of_test();
   end
   // Whole run is a few hundred cycles; this bound of 20,000 cycles leaves wide margin.
   initial
   begin
      #200000;
      n_errors++;
      end_of_test();
   end
endmodule // flash_self_program_sequencer_tb
`default_nettype wire
